// ### atr_top.sv
// Purpose: trigger source selection, arm/trigger state and data routing
// Assumes: sample enable from internal divider; inputs synchronous to mclk
// Notes: host side over classic wishbone, local bus as two struct links
//
// Our own choices: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
module atr_top (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic [15:0] adc_sample,
  input wire logic [15:0] mag_db,
  input wire logic ext_trig,
  input wire logic bus_trig,
  input wire logic [7:0] ques_cond,
  input wire logic err_push,
  input wire logic [7:0] err_code,
  input wire atr_pkg::atr_lbus_t lb_left_in,
  input wire atr_pkg::atr_lbus_t lb_right_in,
  output atr_pkg::atr_lbus_t lb_right_out,
  output atr_pkg::atr_lbus_t lb_left_out,
  output logic trig_pulse,
  output logic wait_timeout
);
  typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_TRIG} atr_state_t;

  function automatic logic sel_hit(input logic [31:0] a, input logic [7:0] off);
    sel_hit = (a[7:0] == off) && (a[31:8] == 24'h000000);
  endfunction

  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    if ($signed(v) > $signed(hi)) begin
      clamp16 = hi;
    end else if ($signed(v) < $signed(lo)) begin
      clamp16 = lo;
    end else begin
      clamp16 = v;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register file
  atr_pkg::atr_src_t src_r;
  atr_pkg::atr_lbm_t lbm_r;
  atr_state_t state_r;
  logic slope_neg_r;
  logic port_lbus_r;
  logic [15:0] adc_lvl_r;
  logic [15:0] mag_lvl_r;
  logic [15:0] tmo_r;
  logic [7:0] qevt_r;
  logic [7:0] err_q_r [atr_pkg::ERR_DEPTH];
  logic [3:0] err_cnt_r;
  logic [15:0] hdata_r;
  logic hdata_vld_r;
  logic ins_done_r;
  logic tail_own_r;
  logic [10:0] blk_cnt_r;
  logic req;
  logic wr;
  logic rd;
  logic mapped;
  logic cmd_trig;
  logic cmd_arm;
  logic [31:0] rdata;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign mapped = sel_hit(wb_adr_i, atr_pkg::OFF_CTRL) || sel_hit(wb_adr_i, atr_pkg::OFF_STAT)
    || sel_hit(wb_adr_i, atr_pkg::OFF_ADCLVL) || sel_hit(wb_adr_i, atr_pkg::OFF_MAGLVL)
    || sel_hit(wb_adr_i, atr_pkg::OFF_TMO) || sel_hit(wb_adr_i, atr_pkg::OFF_QEVT)
    || sel_hit(wb_adr_i, atr_pkg::OFF_ERR) || sel_hit(wb_adr_i, atr_pkg::OFF_CMD)
    || sel_hit(wb_adr_i, atr_pkg::OFF_HDATA);
  assign wr = req && mapped && wb_we_i && wb_sel_i[0];
  assign rd = req && mapped && !wb_we_i;
  assign cmd_trig = wr && sel_hit(wb_adr_i, atr_pkg::OFF_CMD) && wb_dat_i[atr_pkg::CMD_TRIG];
  assign cmd_arm = wr && sel_hit(wb_adr_i, atr_pkg::OFF_CMD) && wb_dat_i[atr_pkg::CMD_ARM];

  // single wait state answer: ack or err one cycle after request appears
  always_ff @(posedge mclk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end else begin
      wb_ack_o <= req && mapped;
      wb_err_o <= req && !mapped;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      src_r <= atr_pkg::SRC_AUTO;
      slope_neg_r <= 1'b0;
      port_lbus_r <= 1'b0;
      lbm_r <= atr_pkg::LBM_PIPE;
      adc_lvl_r <= atr_pkg::ADC_LVL_RST;
      mag_lvl_r <= atr_pkg::MAG_LVL_RST;
      tmo_r <= atr_pkg::TMO_RST;
    end else if (wr && sel_hit(wb_adr_i, atr_pkg::OFF_CTRL)) begin
      src_r <= (wb_dat_i[2:0] > 3'h4) ? atr_pkg::SRC_AUTO : atr_pkg::atr_src_t'(wb_dat_i[2:0]);
      slope_neg_r <= wb_dat_i[atr_pkg::CTL_SLOPE];
      port_lbus_r <= wb_dat_i[atr_pkg::CTL_PORT];
      lbm_r <= atr_pkg::atr_lbm_t'(wb_dat_i[atr_pkg::CTL_LBM_LSB +: 2]);
    end else if (wr && sel_hit(wb_adr_i, atr_pkg::OFF_ADCLVL)) begin
      adc_lvl_r <= clamp16(wb_dat_i[15:0], atr_pkg::ADC_LVL_MIN, atr_pkg::ADC_LVL_MAX);
    end else if (wr && sel_hit(wb_adr_i, atr_pkg::OFF_MAGLVL)) begin
      mag_lvl_r <= clamp16(wb_dat_i[15:0], atr_pkg::MAG_LVL_MIN, atr_pkg::MAG_LVL_MAX);
    end else if (wr && sel_hit(wb_adr_i, atr_pkg::OFF_TMO)) begin
      tmo_r <= (wb_dat_i[15:0] == 16'h0000) ? 16'h0001 : wb_dat_i[15:0];
    end
  end

  // questionable events: set wins over the read-clear
  always_ff @(posedge mclk) begin
    if (srst) begin
      qevt_r <= 8'h00;
    end else if (rd && sel_hit(wb_adr_i, atr_pkg::OFF_QEVT)) begin
      qevt_r <= ques_cond;
    end else begin
      qevt_r <= qevt_r | ques_cond;
    end
  end

  // error stack: newest first; a full stack drops the new entry
  logic err_pop;
  assign err_pop = rd && sel_hit(wb_adr_i, atr_pkg::OFF_ERR) && (err_cnt_r != 4'h0);
  always_ff @(posedge mclk) begin
    if (srst) begin
      err_cnt_r <= 4'h0;
    end else if (err_pop && !err_push) begin
      err_cnt_r <= err_cnt_r - 4'h1;
    end else if (err_push && !err_pop && err_cnt_r != 4'(atr_pkg::ERR_DEPTH)) begin
      err_cnt_r <= err_cnt_r + 4'h1;
    end
  end
  always_ff @(posedge mclk) begin
    if (err_push && err_pop) begin
      err_q_r[err_cnt_r[2:0] - 3'h1] <= err_code;
    end else if (err_push && err_cnt_r != 4'(atr_pkg::ERR_DEPTH)) begin
      err_q_r[err_cnt_r[2:0]] <= err_code;
    end
  end

  always_comb begin
    rdata = 32'h00000000;
    if (sel_hit(wb_adr_i, atr_pkg::OFF_CTRL)) begin
      rdata[6:0] = {lbm_r, port_lbus_r, slope_neg_r, src_r};
    end else if (sel_hit(wb_adr_i, atr_pkg::OFF_STAT)) begin
      rdata[4:0] = {err_cnt_r != 4'h0, hdata_vld_r, wait_timeout, state_r};
    end else if (sel_hit(wb_adr_i, atr_pkg::OFF_ADCLVL)) begin
      rdata[15:0] = adc_lvl_r;
    end else if (sel_hit(wb_adr_i, atr_pkg::OFF_MAGLVL)) begin
      rdata[15:0] = mag_lvl_r;
    end else if (sel_hit(wb_adr_i, atr_pkg::OFF_TMO)) begin
      rdata[15:0] = tmo_r;
    end else if (sel_hit(wb_adr_i, atr_pkg::OFF_QEVT)) begin
      rdata[7:0] = qevt_r;
    end else if (sel_hit(wb_adr_i, atr_pkg::OFF_ERR)) begin
      // bit 8 set means no error; code then reads 0
      rdata[8:0] = (err_cnt_r == 4'h0) ? 9'h100 : {1'b0, err_q_r[err_cnt_r[2:0] - 3'h1]};
    end else if (sel_hit(wb_adr_i, atr_pkg::OFF_HDATA)) begin
      rdata[16:0] = {hdata_vld_r, hdata_r};
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_dat_o <= rd ? rdata : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample enable and trigger detection
  logic [3:0] div_r;
  logic smp_en;
  assign smp_en = (div_r == 4'(atr_pkg::SAMPLE_DIV - 1));
  always_ff @(posedge mclk) begin
    if (srst || smp_en) begin
      div_r <= 4'h0;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end

  logic adc_above_r;
  logic mag_above_r;
  logic ext_r;
  logic cond;
  logic cond_r;
  logic edge_hit;
  logic signed [16:0] adc_hi;
  logic signed [16:0] adc_lo;
  // one guard bit so a level near full scale cannot wrap the band
  assign adc_hi = $signed({adc_lvl_r[15], adc_lvl_r}) + $signed({1'b0, atr_pkg::ADC_HYST});
  assign adc_lo = $signed({adc_lvl_r[15], adc_lvl_r}) - $signed({1'b0, atr_pkg::ADC_HYST});
  // conditions only move on a sample enable, so shorter pulses can be missed
  always_ff @(posedge mclk) begin
    if (srst) begin
      adc_above_r <= 1'b0;
      mag_above_r <= 1'b0;
      ext_r <= 1'b0;
    end else if (smp_en) begin
      ext_r <= ext_trig;
      if ($signed({adc_sample[15], adc_sample}) > adc_hi) begin
        adc_above_r <= 1'b1;
      end else if ($signed({adc_sample[15], adc_sample}) < adc_lo) begin
        adc_above_r <= 1'b0;
      end
      if ($signed(mag_db) >= $signed(mag_lvl_r)) begin
        mag_above_r <= 1'b1;
      end else if ($signed(mag_db) < $signed(mag_lvl_r) - $signed(atr_pkg::MAG_HYST)) begin
        mag_above_r <= 1'b0;
      end
    end
  end

  always_comb begin
    unique case (src_r)
      atr_pkg::SRC_ADC: cond = adc_above_r;
      atr_pkg::SRC_MAG: cond = mag_above_r;
      atr_pkg::SRC_EXT: cond = ext_r;
      default: cond = 1'b0;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      cond_r <= 1'b0;
    end else if (smp_en) begin
      cond_r <= cond;
    end
  end
  assign edge_hit = smp_en && (slope_neg_r ? (cond_r && !cond) : (!cond_r && cond));

  ////////////////////////////////////////////////////////////////////////////
  // measurement state
  logic fire;
  logic blk_end;
  always_comb begin
    unique case (src_r)
      atr_pkg::SRC_OFF: fire = 1'b0;
      atr_pkg::SRC_AUTO: fire = 1'b1;
      default: fire = edge_hit;
    endcase
    fire = fire || cmd_trig || bus_trig;
  end
  assign blk_end = smp_en && (blk_cnt_r == 11'(atr_pkg::BLK_LEN - 1));

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r <= ST_IDLE;
      trig_pulse <= 1'b0;
    end else begin
      trig_pulse <= 1'b0;
      unique case (state_r)
        ST_IDLE: if (cmd_arm) begin
          state_r <= ST_ARM;
        end
        ST_ARM: if (fire) begin
          state_r <= ST_TRIG;
          trig_pulse <= 1'b1;
        end
        ST_TRIG: if (blk_end) begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // wait timer counts while armed, in whole seconds
  logic [26:0] sec_cnt_r;
  logic [15:0] secs_r;
  always_ff @(posedge mclk) begin
    if (srst || state_r != ST_ARM) begin
      sec_cnt_r <= 27'h0;
      secs_r <= 16'h0;
      wait_timeout <= 1'b0;
    end else if (sec_cnt_r == 27'(atr_pkg::SEC_CYC - 1)) begin
      sec_cnt_r <= 27'h0;
      secs_r <= secs_r + 16'h1;
      if (secs_r + 16'h1 >= tmo_r) begin
        wait_timeout <= 1'b1;
      end
    end else begin
      sec_cnt_r <= sec_cnt_r + 27'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data routing
  logic own_lbus;
  logic gen_on;
  assign own_lbus = port_lbus_r && state_r == ST_TRIG && smp_en;
  assign gen_on = (lbm_r == atr_pkg::LBM_GEN) || (lbm_r == atr_pkg::LBM_INS && !ins_done_r);

  always_ff @(posedge mclk) begin
    if (srst || state_r != ST_TRIG) begin
      blk_cnt_r <= 11'h0;
    end else if (smp_en) begin
      blk_cnt_r <= blk_cnt_r + 11'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || lbm_r != atr_pkg::LBM_INS) begin
      ins_done_r <= 1'b0;
    end else if (own_lbus && gen_on && blk_end) begin
      ins_done_r <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || lbm_r != atr_pkg::LBM_TAIL) begin
      tail_own_r <= 1'b0;
    end else if (lb_right_in.valid && lb_right_in.last) begin
      tail_own_r <= 1'b1;
    end else if (own_lbus && blk_end) begin
      tail_own_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      lb_right_out <= '0;
      lb_left_out <= '0;
    end else begin
      lb_right_out <= lb_left_in;
      lb_left_out <= '0;
      if (port_lbus_r && gen_on) begin
        lb_right_out <= '{data: adc_sample, last: blk_end, valid: own_lbus};
      end else if (port_lbus_r && lbm_r == atr_pkg::LBM_TAIL) begin
        lb_right_out <= '0;
        if (tail_own_r) begin
          lb_left_out <= '{data: adc_sample, last: blk_end, valid: own_lbus};
        end else begin
          lb_left_out <= lb_right_in;
        end
      end
    end
  end

  // host data register holds the latest triggered sample taken with the host port selected
  always_ff @(posedge mclk) begin
    if (srst) begin
      hdata_r <= 16'h0000;
      hdata_vld_r <= 1'b0;
    end else if (!port_lbus_r && state_r == ST_TRIG && smp_en) begin
      hdata_r <= adc_sample;
      hdata_vld_r <= 1'b1;
    end else if (rd && sel_hit(wb_adr_i, atr_pkg::OFF_HDATA)) begin
      hdata_vld_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  auto_fires_a: assert property (@(posedge mclk) disable iff (srst)
    state_r == ST_ARM && src_r == atr_pkg::SRC_AUTO |=> state_r == ST_TRIG)
    else $error("auto source did not trigger");
  off_holds_a: assert property (@(posedge mclk) disable iff (srst)
    state_r == ST_ARM && src_r == atr_pkg::SRC_OFF && !cmd_trig && !bus_trig |=> state_r == ST_ARM)
    else $error("off source left armed state");
  man_trig_a: assert property (@(posedge mclk) disable iff (srst)
    state_r == ST_ARM && cmd_trig |=> state_r == ST_TRIG && trig_pulse)
    else $error("manual trigger ignored");
  qevt_clear_a: assert property (@(posedge mclk) disable iff (srst)
    rd && sel_hit(wb_adr_i, atr_pkg::OFF_QEVT) && ques_cond == 8'h00 |=> qevt_r == 8'h00)
    else $error("event register not cleared by read");
  adc_clamp_a: assert property (@(posedge mclk) disable iff (srst)
    wr && sel_hit(wb_adr_i, atr_pkg::OFF_ADCLVL) |=> adc_lvl_r == $past(wb_dat_i[15:0]))
    else $error("adc level not stored");
  mag_range_a: assert property (@(posedge mclk) disable iff (srst)
    $signed(mag_lvl_r) >= $signed(atr_pkg::MAG_LVL_MIN) && $signed(mag_lvl_r) <= $signed(atr_pkg::MAG_LVL_MAX))
    else $error("magnitude level out of range");
  cond_hold_a: assert property (@(posedge mclk) disable iff (srst)
    !smp_en |=> $stable(cond_r))
    else $error("condition moved off sample enable");
  pipe_fwd_a: assert property (@(posedge mclk) disable iff (srst)
    !port_lbus_r |=> lb_right_out == $past(lb_left_in))
    else $error("pipeline did not forward");
  err_empty_a: assert property (@(posedge mclk) disable iff (srst)
    rd && sel_hit(wb_adr_i, atr_pkg::OFF_ERR) && err_cnt_r == 4'h0 |=> wb_dat_o == 32'h00000100)
    else $error("empty error read wrong");
endmodule

// ### atr_pkg.sv
// Purpose: shared constants and types for trigger and output routing
// Assumes: 32-bit classic wishbone, byte addresses, one word per register
// Notes: the adc level is q1.15 of converter full scale; the magnitude level is in tenths of a dB
package atr_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_ADCLVL = 8'h08;
  localparam logic [7:0] OFF_MAGLVL = 8'h0c;
  localparam logic [7:0] OFF_TMO = 8'h10;
  localparam logic [7:0] OFF_QEVT = 8'h14;
  localparam logic [7:0] OFF_ERR = 8'h18;
  localparam logic [7:0] OFF_CMD = 8'h1c;
  localparam logic [7:0] OFF_HDATA = 8'h20;
  // control field positions
  localparam int CTL_SRC_LSB = 0;
  localparam int CTL_SLOPE = 3;
  localparam int CTL_PORT = 4;
  localparam int CTL_LBM_LSB = 5;
  // command bits
  localparam int CMD_TRIG = 0;
  localparam int CMD_ARM = 1;
  // reset values, limits and hysteresis
  localparam logic [15:0] ADC_LVL_RST = 16'h0000;
  localparam logic [15:0] ADC_LVL_MAX = 16'h7fff;
  localparam logic [15:0] ADC_LVL_MIN = 16'h8000;
  localparam logic [15:0] ADC_HYST = 16'h0040;
  // magnitude level in tenths of a dB, signed
  localparam logic [15:0] MAG_LVL_RST = 16'h0000;
  localparam logic [15:0] MAG_LVL_MAX = 16'h001e;
  localparam logic [15:0] MAG_LVL_MIN = 16'hfcae;
  localparam logic [15:0] MAG_HYST = 16'h001e;
  localparam logic [15:0] TMO_RST = 16'h0005;
  localparam int ERR_DEPTH = 8;
  localparam int BLK_LEN = 1024;
  // timing
  localparam int CLK_HZ = 100000000;
  localparam int SEC_CYC = CLK_HZ / 1;
  localparam int SAMPLE_HZ = 10000000;
  localparam int SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;

  typedef enum logic [2:0] {SRC_OFF, SRC_AUTO, SRC_ADC, SRC_MAG, SRC_EXT} atr_src_t;
  typedef enum logic [1:0] {LBM_PIPE, LBM_GEN, LBM_TAIL, LBM_INS} atr_lbm_t;
  typedef struct packed {
    logic [15:0] data;
    logic last;
    logic valid;
  } atr_lbus_t;
endpackage

// ### atr_nbr.sv
// Purpose: left and right neighbours on the daisy-chained local bus
// Assumes: neighbours are clocked by mclk and send one word per cycle
// Notes: the idle word after a frame carries inverted data so a stale value never looks valid
`timescale 1ns/100ps
module atr_nbr (
  input wire logic mclk,
  output atr_pkg::atr_lbus_t to_left_in,
  output atr_pkg::atr_lbus_t to_right_in
);
  initial begin
    to_left_in = '0;
    to_right_in = '0;
  end
  ////////////////////////////////////////////////////////////////
  // each word stands for a whole clock, frame closes with last
  task automatic send(input bit right, input int n, input logic [15:0] base);
    atr_pkg::atr_lbus_t w;
    w = '0;
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      w.data = base + i[15:0];
      w.last = (i == n - 1);
      w.valid = 1'b1;
      if (right) to_right_in <= w;
      else to_left_in <= w;
    end
    @(posedge mclk);
    w.data = ~w.data;
    w.last = 1'b0;
    w.valid = 1'b0;
    if (right) to_right_in <= w;
    else to_left_in <= w;
  endtask
endmodule

// ### acq_trigger_and_output_routing_bench.sv
// Purpose: self-checking bench for trigger and output routing
// Assumes: classic wishbone master, neighbours from atr_nbr
// Notes: timeout register is only read back, one second is 1e8 cycles
`timescale 1ns/100ps
module acq_trigger_and_output_routing_bench;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [31:0] wb_adr_i = '0;
  logic [31:0] wb_dat_i = '0;
  logic [3:0] wb_sel_i = '0;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic wb_err_o;
  logic [15:0] adc_sample = '0;
  logic [15:0] mag_db = 16'hfc18;
  logic ext_trig = 1'b0;
  logic bus_trig = 1'b0;
  logic [7:0] ques_cond = '0;
  logic err_push = 1'b0;
  logic [7:0] err_code = '0;
  atr_pkg::atr_lbus_t lb_left_in, lb_right_in, lb_right_out, lb_left_out;
  logic trig_pulse;
  logic wait_timeout;
  int fail_count = 0;
  int samples_checked = 0;
  int trig_cnt = 0;
  int r_cnt = 0;
  int r_last = 0;
  int l_cnt = 0;
  logic [15:0] r_data = '0;
  logic [31:0] rd;
  logic bus_err;

  atr_top dut (.mclk(mclk), .srst(srst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .adc_sample(adc_sample), .mag_db(mag_db), .ext_trig(ext_trig), .bus_trig(bus_trig),
    .ques_cond(ques_cond), .err_push(err_push), .err_code(err_code), .lb_left_in(lb_left_in),
    .lb_right_in(lb_right_in), .lb_right_out(lb_right_out), .lb_left_out(lb_left_out),
    .trig_pulse(trig_pulse), .wait_timeout(wait_timeout));
  atr_nbr nbr (.mclk(mclk), .to_left_in(lb_left_in), .to_right_in(lb_right_in));

  initial begin
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (trig_pulse === 1'b1) trig_cnt++;
    if (lb_right_out.valid === 1'b1) begin
      r_cnt++;
      r_data = lb_right_out.data;
      if (lb_right_out.last === 1'b1) r_last++;
    end
    if (lb_left_out.valid === 1'b1) l_cnt++;
  end
  ////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one classic cycle, held until ack or err is sampled high
  task automatic wb(input bit we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {24'h000000, adr};
    wb_dat_i <= dat;
    wb_sel_i <= 4'hf;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
    if (n >= 50) check("wb answer", 32'h0, 32'h1);
    rd = wb_dat_o;
    bus_err = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    check(what, rd, exp);
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      wb(1'b0, atr_pkg::OFF_STAT, 32'h0);
      k++;
    end while (rd[1:0] !== 2'h0 && k < 6000);
    check("back to idle", {30'h0, rd[1:0]}, 32'h0);
  endtask
  // kind 0 ext, 1 adc level, 2 magnitude; active drives the crossing
  task automatic drive(input int kind, input bit active);
    @(posedge mclk);
    case (kind)
      0: ext_trig <= active;
      1: adc_sample <= active ? 16'h2000 : 16'h0000;
      default: mag_db <= active ? 16'h0000 : 16'hfc18;
    endcase
  endtask
  task automatic arm_case(input logic [31:0] ctrl, input int kind, input bit fire_first);
    int t;
    wb(1'b1, atr_pkg::OFF_CTRL, ctrl);
    t = trig_cnt;
    wb(1'b1, atr_pkg::OFF_CMD, 32'h2);
    repeat (60) @(posedge mclk);
    check("armed state", trig_cnt, t);
    drive(kind, 1'b1);
    repeat (40) @(posedge mclk);
    check("first edge", trig_cnt, t + fire_first);
    if (!fire_first) begin
      drive(kind, 1'b0);
      repeat (40) @(posedge mclk);
      check("falling edge", trig_cnt, t + 1);
    end
    // host data from the auto run and the host-port 0x0c run is never read again, so its valid bit stays up
    rd_chk("triggered state", atr_pkg::OFF_STAT, 32'ha);
    drive(kind, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    rd_chk("ctrl reset", atr_pkg::OFF_CTRL, 32'h1);
    rd_chk("adc level reset", atr_pkg::OFF_ADCLVL, 32'h0);
    rd_chk("mag level reset", atr_pkg::OFF_MAGLVL, 32'h0);
    rd_chk("timeout reset", atr_pkg::OFF_TMO, 32'h5);
    wb(1'b0, 8'h80, 32'h0);
    check("unmapped err", bus_err, 1'b1);
    wb(1'b1, atr_pkg::OFF_TMO, 32'h8);
    rd_chk("timeout back", atr_pkg::OFF_TMO, 32'h8);
    wb(1'b1, atr_pkg::OFF_MAGLVL, 32'h64);
    rd_chk("mag clamp high", atr_pkg::OFF_MAGLVL, {16'h0, atr_pkg::MAG_LVL_MAX});
    wb(1'b1, atr_pkg::OFF_MAGLVL, 32'hfc00);
    rd_chk("mag clamp low", atr_pkg::OFF_MAGLVL, {16'h0, atr_pkg::MAG_LVL_MIN});
    wb(1'b1, atr_pkg::OFF_ADCLVL, 32'h8000);
    rd_chk("adc level min", atr_pkg::OFF_ADCLVL, {16'h0, atr_pkg::ADC_LVL_MIN});
    @(posedge mclk);
    ques_cond <= 8'h05;
    @(posedge mclk);
    ques_cond <= 8'h00;
    rd_chk("qevent read", atr_pkg::OFF_QEVT, 32'h5);
    rd_chk("qevent cleared", atr_pkg::OFF_QEVT, 32'h0);
    for (int i = 1; i <= 3; i++) begin
      @(posedge mclk);
      err_push <= 1'b1;
      err_code <= 8'h10 + i[7:0];
    end
    @(posedge mclk);
    err_push <= 1'b0;
    for (int i = 3; i >= 1; i--) rd_chk("error pop", atr_pkg::OFF_ERR, 32'h10 + i);
    rd_chk("error empty", atr_pkg::OFF_ERR, 32'h100);
    nbr.send(1'b0, 3, 16'h0a00);
    repeat (3) @(posedge mclk);
    check("pipe count", r_cnt, 3);
    check("pipe data", r_data, 16'h0a02);
    // source off stays armed until manual trigger
    wb(1'b1, atr_pkg::OFF_CTRL, 32'h0);
    wb(1'b1, atr_pkg::OFF_CMD, 32'h2);
    repeat (300) @(posedge mclk);
    rd_chk("off stays armed", atr_pkg::OFF_STAT, 32'h1);
    check("off no trigger", trig_cnt, 0);
    wb(1'b1, atr_pkg::OFF_CMD, 32'h1);
    repeat (12) @(posedge mclk);
    check("manual trigger", trig_cnt, 1);
    // host port: a sample enable has passed, so host data is valid
    rd_chk("manual triggered", atr_pkg::OFF_STAT, 32'ha);
    wait_idle();
    // source still off: a bus trigger pulse also ends the armed state
    wb(1'b1, atr_pkg::OFF_CMD, 32'h2);
    @(posedge mclk);
    bus_trig <= 1'b1;
    @(posedge mclk);
    bus_trig <= 1'b0;
    repeat (3) @(posedge mclk);
    check("bus trigger", trig_cnt, 2);
    wait_idle();
    // auto, generate mode but host port: no own data on the local bus
    adc_sample <= 16'h1234;
    r_cnt = 0;
    wb(1'b1, atr_pkg::OFF_CTRL, 32'h21);
    wb(1'b1, atr_pkg::OFF_CMD, 32'h2);
    repeat (30) @(posedge mclk);
    check("auto trigger", trig_cnt, 3);
    rd_chk("host data", atr_pkg::OFF_HDATA, 32'h11234);
    wait_idle();
    check("host port no lbus", r_cnt, 0);
    adc_sample <= 16'h0000;
    r_cnt = 0;
    r_last = 0;
    arm_case(32'h34, 0, 1'b1);
    wait_idle();
    check("gen words", r_cnt, atr_pkg::BLK_LEN);
    check("gen last", r_last, 1);
    arm_case(32'h0c, 0, 1'b0);
    wait_idle();
    wb(1'b1, atr_pkg::OFF_ADCLVL, 32'h1000);
    // let the comparator settle on the new level before the source switches
    repeat (20) @(posedge mclk);
    r_cnt = 0;
    arm_case(32'h72, 1, 1'b1);
    wait_idle();
    check("insert block", r_cnt, atr_pkg::BLK_LEN);
    nbr.send(1'b0, 2, 16'h0b00);
    repeat (3) @(posedge mclk);
    check("insert then pipe", r_cnt, atr_pkg::BLK_LEN + 2);
    check("insert pipe data", r_data, 16'h0b01);
    wb(1'b1, atr_pkg::OFF_MAGLVL, 32'hffce);
    wb(1'b1, atr_pkg::OFF_CTRL, 32'h53);
    l_cnt = 0;
    nbr.send(1'b1, 4, 16'h0c00);
    arm_case(32'h53, 2, 1'b1);
    wait_idle();
    check("tail add words", l_cnt, 4 + atr_pkg::BLK_LEN);
    test_done();
  end
  initial begin
    repeat (100000) @(posedge mclk);
    fail_count++;
    test_done();
  end
endmodule
